// ===== design/jlp_consts.svh
// constants for the jesd link parameter block
`ifndef JLP_CONSTS_SVH
`define JLP_CONSTS_SVH

// ==========================================================
// apb register map
`define JLP_ADDR_W       12
`define JLP_OFS_MODE     12'h000
`define JLP_OFS_KM1      12'h004
`define JLP_OFS_DID      12'h008
`define JLP_OFS_CTRL     12'h00c
`define JLP_OFS_STATUS   12'h010
`define JLP_OFS_LANES    12'h014
`define JLP_OFS_CHKSUM   12'h018
`define JLP_OFS_SAMPLE   12'h01c

// ==========================================================
// reset values
`define JLP_RST_MODE     5'h00
`define JLP_RST_KM1      5'h1f
`define JLP_RST_DID      8'h00
`define JLP_RST_SCR      1'b0

// ==========================================================
// lane geometry
`define JLP_LANES        16
`define JLP_LANES_LINK   8
`define JLP_K_MAX        6'h20

// ==========================================================
// fixed configuration values
`define JLP_JESDV        3'h1
`define JLP_SUBCLASSV    3'h1

// ==========================================================
// configuration octet indices
`define JLP_OCT_DID      0
`define JLP_OCT_BID      1
`define JLP_OCT_LID      2
`define JLP_OCT_SCR_L    3
`define JLP_OCT_F        4
`define JLP_OCT_K        5
`define JLP_OCT_M        6
`define JLP_OCT_CS_N     7
`define JLP_OCT_SUB_NP   8
`define JLP_OCT_JV_S     9
`define JLP_OCT_HD_CF    10
`define JLP_OCT_RES1     11
`define JLP_OCT_RES2     12
`define JLP_OCT_CHK      13
`define JLP_OCTETS       14

`endif

// ===== design/jlp_pkg.sv
// types for the jesd link parameter block
`default_nettype none
package jlp_pkg;
  `include "jlp_consts.svh"

  // one row of the operating mode table
  typedef struct packed {
    logic       valid;
    logic       des;
    logic [1:0] links;
    logic [4:0] dec;
    logic [4:0] n;
    logic [1:0] cs;
    logic [4:0] np;
    logic [3:0] l;
    logic [3:0] m;
    logic [3:0] f;
    logic [3:0] s;
    logic [4:0] r_x4;
    logic [5:0] kmin;
    logic [1:0] kstep;
  } jlp_mode_t;

  // per-link fields, already in minus-one form
  typedef struct packed {
    logic [7:0] did;
    logic       scr;
    logic [4:0] l_m1;
    logic [7:0] f_m1;
    logic [4:0] k_m1;
    logic [7:0] m_m1;
    logic [4:0] n_m1;
    logic [4:0] np_m1;
    logic [4:0] s_m1;
  } jlp_link_t;

  typedef logic [`JLP_OCTETS-1:0][7:0] jlp_ilas_t;
endpackage : jlp_pkg
`default_nettype wire

// ===== design/jlp_ilas_lane.sv
// per-lane alignment configuration octets and checksum
`timescale 1ns/1ps
`default_nettype none
`include "jlp_consts.svh"

module jlp_ilas_lane
(
  // link fields and lane number
  input  wire logic [4:0]      lid_in,
  input  wire jlp_pkg::jlp_link_t link_in,
  // configuration octets
  output var  jlp_pkg::jlp_ilas_t cfg_out
);
  import jlp_pkg::*;

  // ==========================================================
  // octet packing
  always_comb
  begin
    cfg_out                    = '0;
    cfg_out[`JLP_OCT_DID]      = link_in.did;
    cfg_out[`JLP_OCT_LID]      = {3'h0, lid_in};
    cfg_out[`JLP_OCT_SCR_L]    = {link_in.scr, 2'h0, link_in.l_m1};
    cfg_out[`JLP_OCT_F]        = link_in.f_m1;
    cfg_out[`JLP_OCT_K]        = {3'h0, link_in.k_m1};
    cfg_out[`JLP_OCT_M]        = link_in.m_m1;
    // cs reported zero even where samples carry a control bit
    cfg_out[`JLP_OCT_CS_N]     = {3'h0, link_in.n_m1};
    cfg_out[`JLP_OCT_SUB_NP]   = {`JLP_SUBCLASSV, link_in.np_m1};
    cfg_out[`JLP_OCT_JV_S]     = {`JLP_JESDV, link_in.s_m1};
    // zero fields add nothing, so they are left out of the sum
    cfg_out[`JLP_OCT_CHK]      = link_in.did + 8'(lid_in) + 8'(link_in.scr)
                               + 8'(link_in.l_m1) + link_in.f_m1
                               + 8'(link_in.k_m1) + link_in.m_m1
                               + 8'(link_in.n_m1) + 8'(`JLP_SUBCLASSV)
                               + 8'(link_in.np_m1) + 8'(`JLP_JESDV)
                               + 8'(link_in.s_m1);
  end
endmodule : jlp_ilas_lane
`default_nettype wire

// ===== design/jlp_link_param.sv
// jesd link parameter derivation with apb register access
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "jlp_consts.svh"

// What this block does
// - derive link parameters except K, identifier and scrambler from mode code
// - interleave flag one single, zero dual
// - lane rate factor times device clock
// - programmed frames per multiframe used, reported
// - send all format fields during alignment
// - adjust, bank, cf, hd, reserved report zero
// - control bits per sample reported zero in octets, table value in sample register
// - standard revision one, subclass one
// - software identifier placed in link configuration
// - scrambler bit set by software, reported
// - checksum is field sum modulo 256
// - converter count governs packing only
// - second link reports identifier plus one
// - lowest lanes used, others powered down
module jlp_link_param
(
  // clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rstn_in,
  // apb slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [11:0]           paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output var  logic                  pready_out,
  output var  logic [31:0]           prdata_out,
  output var  logic                  pslverr_out,
  // derived operating state
  output var  logic                  mode_valid_out,
  output var  logic                  k_in_range_out,
  output var  logic                  interleave_out,
  output var  logic [4:0]            decimation_out,
  output var  logic [4:0]            lane_rate_x4_out,
  output var  logic [1:0]            link_count_out,
  output var  logic [5:0]            frames_per_multiframe_out,
  output var  logic                  scramble_en_out,
  // lanes
  output var  logic [15:0]           lane_en_out,
  output var  jlp_pkg::jlp_ilas_t [15:0] ilas_cfg_out
);
  import jlp_pkg::*;

  // ==========================================================
  // mode table
  function automatic jlp_mode_t jlp_mode_lookup(input logic [4:0] code);
    jlp_mode_t m;
    m = '0;
    case (code)
      5'h00: m = '{1'b1,1'b1,2'h2,5'h01,5'h0c,2'h0,5'h0c,4'h4,4'h4,4'h8,4'h5,5'h10,6'h03,2'h1};
      5'h01: m = '{1'b1,1'b1,2'h2,5'h01,5'h0c,2'h0,5'h0c,4'h8,4'h8,4'h8,4'h5,5'h08,6'h03,2'h1};
      5'h02: m = '{1'b1,1'b0,2'h2,5'h01,5'h0c,2'h0,5'h0c,4'h4,4'h4,4'h8,4'h5,5'h10,6'h03,2'h1};
      5'h03: m = '{1'b1,1'b0,2'h2,5'h01,5'h0c,2'h0,5'h0c,4'h8,4'h8,4'h8,4'h5,5'h08,6'h03,2'h1};
      5'h04: m = '{1'b1,1'b1,2'h2,5'h01,5'h08,2'h0,5'h08,4'h2,4'h1,4'h1,4'h2,5'h14,6'h12,2'h2};
      5'h05: m = '{1'b1,1'b1,2'h2,5'h01,5'h08,2'h0,5'h08,4'h4,4'h1,4'h1,4'h4,5'h0a,6'h12,2'h2};
      5'h06: m = '{1'b1,1'b0,2'h2,5'h01,5'h08,2'h0,5'h08,4'h2,4'h1,4'h1,4'h2,5'h14,6'h12,2'h2};
      5'h07: m = '{1'b1,1'b0,2'h2,5'h01,5'h08,2'h0,5'h08,4'h4,4'h1,4'h1,4'h4,5'h0a,6'h12,2'h2};
      5'h09: m = '{1'b1,1'b0,2'h2,5'h02,5'h0f,2'h1,5'h10,4'h4,4'h1,4'h2,4'h4,5'h0a,6'h09,2'h1};
      5'h0a: m = '{1'b1,1'b0,2'h2,5'h04,5'h0f,2'h1,5'h10,4'h2,4'h2,4'h2,4'h1,5'h14,6'h09,2'h1};
      5'h0b: m = '{1'b1,1'b0,2'h2,5'h04,5'h0f,2'h1,5'h10,4'h4,4'h2,4'h2,4'h2,5'h0a,6'h09,2'h1};
      5'h0c: m = '{1'b1,1'b0,2'h2,5'h04,5'h0c,2'h0,5'h0c,4'h8,4'h8,4'h8,4'h5,5'h04,6'h03,2'h1};
      5'h0d: m = '{1'b1,1'b0,2'h2,5'h08,5'h0f,2'h1,5'h10,4'h1,4'h2,4'h4,4'h1,5'h14,6'h05,2'h1};
      5'h0e: m = '{1'b1,1'b0,2'h2,5'h08,5'h0f,2'h1,5'h10,4'h2,4'h2,4'h2,4'h1,5'h0a,6'h09,2'h1};
      5'h0f: m = '{1'b1,1'b0,2'h1,5'h10,5'h0f,2'h1,5'h10,4'h1,4'h4,4'h8,4'h1,5'h14,6'h03,2'h1};
      5'h10: m = '{1'b1,1'b0,2'h2,5'h10,5'h0f,2'h1,5'h10,4'h1,4'h2,4'h4,4'h1,5'h0a,6'h05,2'h1};
      5'h11: m = '{1'b1,1'b1,2'h2,5'h01,5'h08,2'h0,5'h08,4'h8,4'h1,4'h1,4'h8,5'h05,6'h12,2'h2};
      5'h12: m = '{1'b1,1'b0,2'h2,5'h01,5'h08,2'h0,5'h08,4'h8,4'h1,4'h1,4'h8,5'h05,6'h12,2'h2};
      // reserved and undefined codes leave every lane down
      default: m = '0;
    endcase
    return m;
  endfunction : jlp_mode_lookup

  // ==========================================================
  // declarations
  logic [4:0]        link_mode_code_r;
  logic [4:0]        frames_per_multiframe_less_one_r;
  logic [7:0]        device_id_r;
  logic              scramble_en_r;
  jlp_mode_t         mode_r;
  jlp_link_t [1:0]   link_cfg_r;
  logic [5:0]        k_val;
  logic [5:0]        k_off;
  logic              k_ok;
  logic              apb_setup;
  logic              apb_write;
  logic              addr_ok;
  logic [31:0]       rd_data;
  logic [15:0]       lane_en_nxt;
  jlp_ilas_t [15:0]  lane_cfg;

  assign apb_setup = psel_in & ~penable_in & ~pready_out;
  assign apb_write = psel_in & penable_in & pready_out & pwrite_in & addr_ok;

  // ==========================================================
  // apb address decode and read mux
  always_comb
  begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr_in)
      `JLP_OFS_MODE:   rd_data = {27'h000_0000, link_mode_code_r};
      `JLP_OFS_KM1:    rd_data = {27'h000_0000, frames_per_multiframe_less_one_r};
      `JLP_OFS_DID:    rd_data = {24'h00_0000, device_id_r};
      `JLP_OFS_CTRL:   rd_data = {31'h0000_0000, scramble_en_r};
      `JLP_OFS_STATUS: rd_data = {1'b0, mode_r.s, mode_r.f, mode_r.m, mode_r.l,
                                  mode_r.r_x4, mode_r.dec, mode_r.links,
                                  mode_r.des, k_in_range_out, mode_r.valid};
      `JLP_OFS_LANES:  rd_data = {16'h0000, lane_en_out};
      `JLP_OFS_CHKSUM: rd_data = {16'h0000,
                                  ilas_cfg_out[`JLP_LANES_LINK][`JLP_OCT_CHK],
                                  ilas_cfg_out[0][`JLP_OCT_CHK]};
      `JLP_OFS_SAMPLE: rd_data = {20'h0_0000, mode_r.np, mode_r.cs, mode_r.n};
      default:
      begin
        addr_ok = 1'b0;
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================
  // apb answer: one cycle after setup, so no wait states
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      pready_out <= 1'b0;
    else
      pready_out <= apb_setup;
  end

  // read data stands only with ready, so no stale word lingers
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      prdata_out <= 32'h0000_0000;
    else if (apb_setup && !pwrite_in)
      prdata_out <= rd_data;
    else
      prdata_out <= 32'h0000_0000;
  end

  // unmapped words refused both ways; such writes are dropped
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      pslverr_out <= 1'b0;
    else
      pslverr_out <= apb_setup & ~addr_ok;
  end

  // ==========================================================
  // software registers
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      link_mode_code_r <= `JLP_RST_MODE;
    else if (apb_write && paddr_in == `JLP_OFS_MODE)
      link_mode_code_r <= pwdata_in[4:0];
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      frames_per_multiframe_less_one_r <= `JLP_RST_KM1;
    else if (apb_write && paddr_in == `JLP_OFS_KM1)
      frames_per_multiframe_less_one_r <= pwdata_in[4:0];
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      device_id_r <= `JLP_RST_DID;
    else if (apb_write && paddr_in == `JLP_OFS_DID)
      device_id_r <= pwdata_in[7:0];
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      scramble_en_r <= `JLP_RST_SCR;
    else if (apb_write && paddr_in == `JLP_OFS_CTRL)
      scramble_en_r <= pwdata_in[0];
  end

  // ==========================================================
  // derived mode, registered to keep the table off the octet path
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      mode_r <= '0;
    else
      mode_r <= jlp_mode_lookup(link_mode_code_r);
  end

  // frame count check; out of range values are flagged, not altered
  always_comb
  begin
    k_val = {1'b0, frames_per_multiframe_less_one_r} + 6'h01;
    k_off = k_val - mode_r.kmin;
    k_ok  = mode_r.valid && k_val >= mode_r.kmin && k_val <= `JLP_K_MAX
            && (mode_r.kstep != 2'h2 || !k_off[0]);
  end

  // ==========================================================
  // per-link fields
  for (genvar k = 0; k < 2; k++)
  begin : g_link
    always_ff @(posedge clk_sys_in)
    begin
      if (!rstn_in)
        link_cfg_r[k] <= '0;
      else
      begin
        link_cfg_r[k].did   <= device_id_r + 8'(k);
        link_cfg_r[k].scr   <= scramble_en_r;
        link_cfg_r[k].l_m1  <= 5'(mode_r.l) - 5'h01;
        link_cfg_r[k].f_m1  <= 8'(mode_r.f) - 8'h01;
        link_cfg_r[k].k_m1  <= frames_per_multiframe_less_one_r;
        link_cfg_r[k].m_m1  <= 8'(mode_r.m) - 8'h01;
        link_cfg_r[k].n_m1  <= mode_r.n - 5'h01;
        link_cfg_r[k].np_m1 <= mode_r.np - 5'h01;
        link_cfg_r[k].s_m1  <= 5'(mode_r.s) - 5'h01;
      end
    end
  end

  // ==========================================================
  // lanes: each has its own octets since the lane number differs
  for (genvar i = 0; i < `JLP_LANES; i++)
  begin : g_lane
    localparam int         LINK = i / `JLP_LANES_LINK;
    localparam logic [4:0] LID  = 5'(i % `JLP_LANES_LINK);

    jlp_ilas_lane u_lane
    (
      .lid_in  (LID),
      .link_in (link_cfg_r[LINK]),
      .cfg_out (lane_cfg[i])
    );

    assign lane_en_nxt[i] = mode_r.valid && (2'(LINK) < mode_r.links)
                            && (LID < 5'(mode_r.l));
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      lane_en_out <= 16'h0000;
    else
      lane_en_out <= lane_en_nxt;
  end

  // octets run for idle lanes too; lane enable alone gates them
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      ilas_cfg_out <= '0;
    else
      ilas_cfg_out <= lane_cfg;
  end

  // ==========================================================
  // derived state outputs
  // invalid codes read back as zero here, except frames per multiframe and scrambler enable
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      mode_valid_out <= 1'b0;
    else
      mode_valid_out <= mode_r.valid;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      k_in_range_out <= 1'b0;
    else
      k_in_range_out <= k_ok;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      interleave_out <= 1'b0;
    else
      interleave_out <= mode_r.des;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      decimation_out <= 5'h00;
    else
      decimation_out <= mode_r.dec;
  end

  // quarter steps because some modes send 1.25 or 2.5 bits a clock
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      lane_rate_x4_out <= 5'h00;
    else
      lane_rate_x4_out <= mode_r.r_x4;
  end

  // same edge as lane enable, so the two never disagree
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      link_count_out <= 2'h0;
    else
      link_count_out <= mode_r.links;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      frames_per_multiframe_out <= 6'h00;
    else
      frames_per_multiframe_out <= k_val;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      scramble_en_out <= 1'b0;
    else
      scramble_en_out <= scramble_en_r;
  end
endmodule : jlp_link_param
`default_nettype wire

// ===== dv/jlp_rx_model.sv
// receiver model that checks one lane's alignment configuration
`timescale 1ns/1ps
`default_nettype none
module jlp_rx_model
(
  // clock
  input  wire logic               clk_sys_in,
  // configuration octets of one lane
  input  wire jlp_pkg::jlp_ilas_t cfg_in,
  // checksum agrees with the fields
  output var  logic               cfg_ok_out
);
  import jlp_pkg::*;
  // ==========
  // field sum, minus-one values as sent
  logic [7:0] sum_nxt;
  always_comb
  begin
    sum_nxt = cfg_in[0] + 8'(cfg_in[2][4:0]) + 8'(cfg_in[3][7]) + 8'(cfg_in[3][4:0])
            + cfg_in[4] + 8'(cfg_in[5][4:0]) + cfg_in[6] + 8'(cfg_in[7][4:0])
            + 8'(cfg_in[8][7:5]) + 8'(cfg_in[8][4:0]) + 8'(cfg_in[9][7:5])
            + 8'(cfg_in[9][4:0]);
  end
  // a real receiver drops the link on a mismatch; here it is only flagged
  always_ff @(posedge clk_sys_in)
  begin
    cfg_ok_out <= (sum_nxt == cfg_in[13]);
  end
endmodule : jlp_rx_model
`default_nettype wire

// ===== dv/jlp_link_param_checker.sv
// assertions on the link parameter block ports
`timescale 1ns/1ps
`default_nettype none
module jlp_link_param_checker
(
  // clock, reset, bus answer
  input  wire logic                      clk_sys_in,
  input  wire logic                      rstn_in,
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pready_out,
  input  wire logic                      pslverr_out,
  // derived state
  input  wire logic                      scramble_en_out,
  input  wire logic [1:0]                link_count_out,
  input  wire logic [15:0]               lane_en_out,
  input  wire jlp_pkg::jlp_ilas_t [15:0] ilas_cfg_out
);
  import jlp_pkg::*;
  // ==========
  // settle count: outputs follow registers from the third edge
  logic [1:0] up_r;
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      up_r <= 2'h0;
    else if (up_r != 2'h3)
      up_r <= up_r + 2'h1;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // ==========
  // bus and configuration checks
  chk_ready_next:
    assert property (psel_in && !penable_in && !pready_out |=> pready_out)
    else $error("ready missing after setup");
  chk_ready_once:
    assert property (pready_out |=> !pready_out)
    else $error("ready held");
  chk_err_ready:
    assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  chk_zero_fields:
    assert property (ilas_cfg_out[0][1] == 8'h00 && ilas_cfg_out[0][10] == 8'h00
      && ilas_cfg_out[0][11] == 8'h00 && ilas_cfg_out[9][12] == 8'h00)
    else $error("fixed zero octet not zero");
  chk_cs_zero:
    assert property (ilas_cfg_out[0][7][7:6] == 2'h0 && ilas_cfg_out[9][7][7:6] == 2'h0)
    else $error("control bits reported");
  chk_version_one:
    assert property (up_r == 2'h3 |-> ilas_cfg_out[0][8][7:5] == 3'h1
      && ilas_cfg_out[9][9][7:5] == 3'h1)
    else $error("version fields wrong");
  chk_did_plus:
    assert property (up_r == 2'h3 |-> ilas_cfg_out[8][0] == ilas_cfg_out[0][0] + 8'h01)
    else $error("second link identifier wrong");
  chk_scr_flag:
    assert property (up_r == 2'h3 |-> ilas_cfg_out[0][3][7] == $past(scramble_en_out))
    else $error("scrambler flag differs");
  chk_lanes_low:
    assert property ((lane_en_out[7:0] & (lane_en_out[7:0] + 8'h01)) == 8'h00
      && (lane_en_out[15:8] & (lane_en_out[15:8] + 8'h01)) == 8'h00)
    else $error("lanes not lowest first");
  chk_one_link:
    assert property (link_count_out == 2'h1 |-> lane_en_out[15:8] == 8'h00)
    else $error("second link lanes on");
  cover property (pslverr_out);
  cover property (link_count_out == 2'h1);
  cover property (scramble_en_out);
endmodule : jlp_link_param_checker
bind jlp_link_param jlp_link_param_checker i_chk (.clk_sys_in(clk_sys_in),
  .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .scramble_en_out(scramble_en_out),
  .link_count_out(link_count_out), .lane_en_out(lane_en_out), .ilas_cfg_out(ilas_cfg_out));
`default_nettype wire

// ===== dv/jlp_link_param_tb_top.sv
// testbench for the jesd link parameter block
`timescale 1ns/1ps
`default_nettype none
`include "jlp_consts.svh"
module jlp_link_param_tb_top;
  import jlp_pkg::*;
  // ==========
  // stimulus and observed signals
  logic             clk_sys_in = 1'b0;
  logic             rstn_in = 1'b0;
  logic             psel_in = 1'b0;
  logic             penable_in = 1'b0;
  logic             pwrite_in = 1'b0;
  logic [11:0]      paddr_in = 12'h000;
  logic [31:0]      pwdata_in = 32'h0000_0000;
  logic             pready_out, pslverr_out, mode_valid_out, k_in_range_out;
  logic             interleave_out, scramble_en_out, rx_ok_a, rx_ok_b;
  logic [31:0]      prdata_out, rd;
  logic [4:0]       decimation_out, lane_rate_x4_out;
  logic [1:0]       link_count_out;
  logic [5:0]       frames_per_multiframe_out;
  logic [15:0]      lane_en_out;
  jlp_ilas_t [15:0] ilas_cfg_out;
  int               miscompares = 0;
  int               check_count = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  jlp_link_param i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .prdata_out(prdata_out),
    .pslverr_out(pslverr_out), .mode_valid_out(mode_valid_out),
    .k_in_range_out(k_in_range_out), .interleave_out(interleave_out),
    .decimation_out(decimation_out), .lane_rate_x4_out(lane_rate_x4_out),
    .link_count_out(link_count_out), .frames_per_multiframe_out(frames_per_multiframe_out),
    .scramble_en_out(scramble_en_out), .lane_en_out(lane_en_out),
    .ilas_cfg_out(ilas_cfg_out));
  jlp_rx_model i_rx_a (.clk_sys_in(clk_sys_in), .cfg_in(ilas_cfg_out[0]), .cfg_ok_out(rx_ok_a));
  jlp_rx_model i_rx_b (.clk_sys_in(clk_sys_in), .cfg_in(ilas_cfg_out[9]), .cfg_ok_out(rx_ok_b));
  // ==========
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic e);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
    end
    while (pready_out !== 1'b1);
    rd = prdata_out;
    chk("bus error", {31'h0, pslverr_out}, {31'h0, e});
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : xfer
  // checksum of mode 0, scrambler on, K 32: 1+3+7+31+3+11+1+11+1+4 past the ids
  function automatic logic [7:0] ck(input logic [7:0] did, input logic [7:0] lid);
    ck = did + lid + 8'h49;
  endfunction : ck
  // ==========
  // scenarios
  task automatic t_reset();
    xfer(1'b0, `JLP_OFS_MODE, 32'h0, 1'b0);
    chk("mode reg", rd, 32'h0000_0000);
    xfer(1'b0, `JLP_OFS_KM1, 32'h0, 1'b0);
    chk("k reg", rd, 32'h0000_001f);
    xfer(1'b0, `JLP_OFS_CTRL, 32'h0, 1'b0);
    chk("ctrl reg", rd, 32'h0000_0000);
  endtask : t_reset
  task automatic t_mode(input logic [4:0] m, input logic des, input logic [4:0] dec,
                        input logic [4:0] rx4, input logic [1:0] lk, input logic [3:0] l);
    logic [7:0]  msk;
    logic [15:0] lx;
    msk = 8'((9'h001 << l) - 9'h001);
    lx = {(lk == 2'h2) ? msk : 8'h00, msk};
    xfer(1'b1, `JLP_OFS_MODE, {27'h0, m}, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    chk("mode valid", {31'h0, mode_valid_out}, {31'h0, lk != 2'h0});
    chk("interleave", {31'h0, interleave_out}, {31'h0, des});
    chk("decimation", {27'h0, decimation_out}, {27'h0, dec});
    chk("lane rate", {27'h0, lane_rate_x4_out}, {27'h0, rx4});
    chk("links", {30'h0, link_count_out}, {30'h0, lk});
    chk("lanes", {16'h0, lane_en_out}, {16'h0, lx});
    xfer(1'b0, `JLP_OFS_LANES, 32'h0, 1'b0);
    chk("lanes reg", rd, {16'h0, lx});
  endtask : t_mode
  task automatic t_ilas();
    xfer(1'b1, `JLP_OFS_MODE, 32'h0000_0000, 1'b0);
    xfer(1'b1, `JLP_OFS_KM1, 32'h0000_001f, 1'b0);
    xfer(1'b1, `JLP_OFS_DID, 32'h0000_00ff, 1'b0);
    xfer(1'b1, `JLP_OFS_CTRL, 32'h0000_0001, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    chk("k", {26'h0, frames_per_multiframe_out}, 32'h0000_0020);
    chk("k range", {31'h0, k_in_range_out}, 32'h0000_0001);
    chk("scrambler", {31'h0, scramble_en_out}, 32'h0000_0001);
    chk("did a", {24'h0, ilas_cfg_out[0][0]}, 32'h0000_00ff);
    chk("did b", {24'h0, ilas_cfg_out[9][0]}, 32'h0000_0000);
    chk("lid b1", {24'h0, ilas_cfg_out[9][2]}, 32'h0000_0001);
    chk("scr l", {24'h0, ilas_cfg_out[9][3]}, 32'h0000_0083);
    chk("f", {24'h0, ilas_cfg_out[9][4]}, 32'h0000_0007);
    chk("k oct", {24'h0, ilas_cfg_out[9][5]}, 32'h0000_001f);
    chk("m", {24'h0, ilas_cfg_out[9][6]}, 32'h0000_0003);
    chk("cs n", {24'h0, ilas_cfg_out[9][7]}, 32'h0000_000b);
    chk("sub np", {24'h0, ilas_cfg_out[9][8]}, 32'h0000_002b);
    chk("jv s", {24'h0, ilas_cfg_out[9][9]}, 32'h0000_0024);
    chk("sum a", {24'h0, ilas_cfg_out[0][13]}, {24'h0, ck(8'hff, 8'h00)});
    chk("sum b1", {24'h0, ilas_cfg_out[9][13]}, {24'h0, ck(8'h00, 8'h01)});
    chk("rx ok", {30'h0, rx_ok_a, rx_ok_b}, 32'h0000_0003);
    xfer(1'b0, `JLP_OFS_CHKSUM, 32'h0, 1'b0);
    chk("sum reg", rd, {16'h0, ck(8'h00, 8'h00), ck(8'hff, 8'h00)});
    xfer(1'b1, `JLP_OFS_MODE, 32'h0000_0009, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    chk("cs n 9", {24'h0, ilas_cfg_out[0][7]}, 32'h0000_000e);
    xfer(1'b0, `JLP_OFS_SAMPLE, 32'h0, 1'b0);
    chk("sample reg", rd, 32'h0000_082f);
  endtask : t_ilas
  task automatic t_bus();
    xfer(1'b0, 12'h020, 32'h0, 1'b1);
    chk("unmapped read", rd, 32'h0000_0000);
    xfer(1'b1, 12'h100, 32'h0000_0003, 1'b1);
    xfer(1'b1, `JLP_OFS_STATUS, 32'hffff_ffff, 1'b0);
    xfer(1'b0, `JLP_OFS_MODE, 32'h0, 1'b0);
    chk("mode kept", rd, 32'h0000_0009);
    xfer(1'b1, `JLP_OFS_KM1, 32'h0000_0004, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    chk("k low", {26'h0, frames_per_multiframe_out}, 32'h0000_0005);
    chk("k out", {31'h0, k_in_range_out}, 32'h0000_0000);
    xfer(1'b0, `JLP_OFS_STATUS, 32'h0, 1'b0);
    chk("status", rd, 32'h210a_2851);
  endtask : t_bus
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // ==========
  // main sequence and watchdog
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    t_reset();
    t_mode(5'h00, 1'b1, 5'h01, 5'h10, 2'h2, 4'h4);
    t_mode(5'h02, 1'b0, 5'h01, 5'h10, 2'h2, 4'h4);
    t_mode(5'h0c, 1'b0, 5'h04, 5'h04, 2'h2, 4'h8);
    t_mode(5'h0d, 1'b0, 5'h08, 5'h14, 2'h2, 4'h1);
    t_mode(5'h0f, 1'b0, 5'h10, 5'h14, 2'h1, 4'h1);
    t_mode(5'h11, 1'b1, 5'h01, 5'h05, 2'h2, 4'h8);
    t_mode(5'h08, 1'b0, 5'h00, 5'h00, 2'h0, 4'h0);
    t_ilas();
    t_bus();
    test_done();
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys_in);
    miscompares++;
    test_done();
  end
endmodule : jlp_link_param_tb_top
`default_nettype wire
